/* File: rtl/asb_buffer.sv */
// Purpose : three-axis acceleration sample buffer with fifo, stream and trigger modes
// Assumes : samples arrive on link_clock; the register port and engine irq on clock
// Notes   : samples on the link are spaced by at least eight core clock periods
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module asb_buffer
    import asb_pkg::*;
#(
    parameter int BUF_BYTES = BUF_BYTES_DEF, // depth in bytes
    parameter int ODR_CYC   = ODR_BASE_CYC   // slowest output rate period in clocks
) (
    input  wire logic        clock,        // core clock, 100 MHz
    input  wire logic        rst,          // async reset, active high
    input  wire logic        link_clock,   // sample front end clock
    input  wire logic        link_valid,   // one link cycle per converted sample
    input  wire logic [11:0] link_x,       // x acceleration, two's complement
    input  wire logic [11:0] link_y,       // y acceleration
    input  wire logic [11:0] link_z,       // z acceleration
    input  wire logic        engine_irq,   // detection engine interrupt, core domain
    input  wire logic [7:0]  addr,         // register index
    input  wire logic [7:0]  wdata,        // write data
    input  wire logic        wr,           // write strobe
    input  wire logic        rd,           // read strobe
    output logic      [7:0]  rdata,        // read data, cycle after rd
    output logic             watermark,    // watermark interrupt level
    output logic             trig_flag     // trigger status flag
);
    typedef logic [7:0] asb_ptr_t;

    //--------------------------------------------------------------------------
    // link domain: hold the latest sample and toggle to announce it
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic [35:0] hold;
        logic        tog;
    } asb_link_t;
    asb_link_t l_q, l_d;

    // capture on the link clock; hold stays put until the next sample
    always_comb begin
        l_d = l_q;
        if (link_valid) begin
            l_d.hold = {link_z, link_y, link_x};
            l_d.tog  = ~l_q.tog;
        end
    end

    always_ff @(posedge link_clock or posedge rst) begin
        if (rst) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    //--------------------------------------------------------------------------
    // core domain state
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic [BUF_BYTES-1:0][7:0] mem;
        asb_ptr_t    wp;
        asb_ptr_t    rp;
        asb_ptr_t    fill;
        logic [2:0]  phase;     // bytes read of the current sample
        logic [7:0]  ctrl;
        logic [6:0]  th;
        logic [35:0] latest;
        logic        s1, s2, s3;
        logic [31:0] odr_cnt;
        logic        pend;
        asb_tstate_t ts;
        logic [7:0]  rdata;
        logic        wm;
        logic        trig;
    } asb_core_t;
    asb_core_t q, d;

    // ring index arithmetic, used by both pointers
    function automatic asb_ptr_t wrap_add(input asb_ptr_t p, input asb_ptr_t n);
        logic [8:0] s;
        s = {1'b0, p} + {1'b0, n};
        if (s >= 9'(BUF_BYTES)) begin
            s = s - 9'(BUF_BYTES);
        end
        return s[7:0];
    endfunction

    // whole samples held for a byte level
    function automatic asb_ptr_t samples_of(input asb_ptr_t f, input logic hi);
        return hi ? f / BYTES_HI : f / BYTES_LO;
    endfunction

    // byte n of a sample in read order
    function automatic logic [7:0] byte_of(input logic [35:0] s, input logic hi,
                                           input int n);
        logic [11:0] ax;
        ax = s[12*(hi ? n/2 : n) +: 12];
        if (!hi) begin
            return ax[11:4];
        end
        return (n % 2 == 0) ? {ax[3:0], 4'h0} : ax[11:4];
    endfunction

    asb_mode_t   mode;
    logic        hi_res;
    asb_ptr_t    bps;
    asb_ptr_t    thb;
    asb_ptr_t    nsamp;
    logic [31:0] period;
    assign mode   = asb_mode_t'(q.ctrl[CTRL_MODE_LSB +: 2]);
    assign hi_res = q.ctrl[CTRL_RES_BIT];
    assign bps    = hi_res ? BYTES_HI : BYTES_LO;
    assign thb    = 8'(q.th * bps);
    assign nsamp  = samples_of(q.fill, hi_res);
    assign period = 32'(ODR_CYC) >> q.ctrl[CTRL_RATE_LSB +: 2];

    // one process for the whole core: bus, rate timer, capture and read-out
    always_comb begin
        logic full;
        logic store;
        logic pop;
        d     = q;
        full  = 1'b0;
        store = 1'b0;
        pop   = 1'b0;
        // crossing: s1 feeds s2 only, edge taken between s2 and s3
        d.s1 = l_q.tog;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 != q.s3) begin
            d.latest = l_q.hold;
        end
        // output rate timer
        if (q.odr_cnt >= period - 32'd1) begin
            d.odr_cnt = '0;
            d.pend    = 1'b1;
        end else begin
            d.odr_cnt = q.odr_cnt + 32'd1;
        end
        // register writes
        if (wr) begin
            if (addr == REG_CTRL) begin
                d.ctrl = wdata;
            end else if (addr == REG_THRESH) begin
                d.th = wdata[6:0];
            end
        end
        // read port pops one byte, oldest first
        d.rdata = '0;
        if (rd) begin
            if (addr == REG_CTRL) begin
                d.rdata = q.ctrl;
            end else if (addr == REG_THRESH) begin
                d.rdata = {1'b0, q.th};
            end else if (addr == REG_STATUS) begin
                d.rdata = {3'h0, q.phase, q.trig, q.wm};
            end else if (addr == REG_FILL) begin
                d.rdata = q.fill;
            end else if (addr == REG_ABOVE) begin
                d.rdata = (nsamp > 8'(q.th)) ? 8'(nsamp - 8'(q.th)) : 8'h00;
            end else if (addr == REG_DATA && q.fill != 8'h00) begin
                d.rdata = q.mem[q.rp];
                pop     = 1'b1;
            end
        end
        if (pop) begin
            d.rp    = wrap_add(q.rp, 8'h01);
            d.fill  = q.fill - 8'h01;
            d.phase = (q.phase + 3'd1 >= 3'(bps)) ? 3'd0 : q.phase + 3'd1;
        end
        // a pending sample waits until no sample is half read
        if (q.pend && q.phase == 3'd0 && !pop) begin
            d.pend = 1'b0;
            full   = 9'(q.fill) + 9'(bps) > 9'(BUF_BYTES);
            store  = 1'b1;
            if (mode == ASB_STREAM && full) begin
                d.rp   = wrap_add(q.rp, bps);
                d.fill = q.fill - bps;
            end else if (mode == ASB_TRIG && q.ts == TS_PRE) begin
                if (q.fill >= thb && q.fill != 8'h00) begin
                    d.rp   = wrap_add(q.rp, bps);
                    d.fill = q.fill - bps;
                end
            end else if (full || (mode == ASB_TRIG && q.ts == TS_DONE)) begin
                store = 1'b0;
                if (mode == ASB_TRIG) begin
                    d.ts = TS_DONE;
                end
            end
        end
        if (store) begin
            for (int i = 0; i < 6; i++) begin
                if (i < int'(bps)) begin
                    d.mem[wrap_add(q.wp, 8'(i))] = byte_of(q.latest, hi_res, i);
                end
            end
            d.wp   = wrap_add(q.wp, bps);
            d.fill = d.fill + bps;
        end
        // clear register: buffer and every latched indication
        if (wr && addr == REG_CLEAR) begin
            d.wp    = '0;
            d.rp    = '0;
            d.fill  = '0;
            d.phase = '0;
            d.pend  = 1'b0;
            d.trig  = 1'b0;
            d.ts    = TS_PRE;
        end
        // trigger event after the clear: an event in the clear cycle is kept only if the state was already TS_PRE
        if (mode == ASB_TRIG && engine_irq && q.ts == TS_PRE) begin
            d.ts = TS_POST;
            if (nsamp >= 8'(q.th)) begin
                d.trig = 1'b1;
            end
        end
        if (mode != ASB_TRIG) begin
            d.ts = TS_PRE;
        end
        d.wm = samples_of(d.fill, hi_res) >= 8'(d.th);
    end

    // register the core state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            q      <= '0;
            q.ctrl <= CTRL_RST;
            q.th   <= THRESH_RST;
            q.ts   <= TS_PRE;
            q.wm   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rdata     = q.rdata;
    assign watermark = q.wm;
    assign trig_flag = q.trig;

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_clear_empties: assert property (
        wr && addr == REG_CLEAR |=> q.fill == 8'h00 && q.rp == q.wp
        && (!trig_flag || $past(engine_irq)))
        else $error("clear did not empty the buffer");
    a_fifo_full_drop: assert property (
        mode == ASB_FIFO && q.pend && q.phase == 3'd0 && !rd && !wr
        && 9'(q.fill) + 9'(bps) > 9'(BUF_BYTES) |=> $stable(q.wp) && $stable(q.fill))
        else $error("full fifo accepted a sample");
    a_stream_keeps: assert property (
        mode == ASB_STREAM && q.pend && q.phase == 3'd0 && !rd && !wr
        && 9'(q.fill) + 9'(bps) > 9'(BUF_BYTES) |=> q.wp != $past(q.wp) && $stable(q.fill))
        else $error("stream mode stopped collecting when full");
    a_read_data: assert property (
        rd && addr == REG_DATA && q.fill != 8'h00 |=> rdata == $past(q.mem[q.rp])
        && q.fill == $past(q.fill) - 8'h01)
        else $error("read port gave the wrong byte");
    a_no_midread: assert property (
        q.phase != 3'd0 && !(wr && addr == REG_CLEAR)
        |=> !($past(q.wp) != q.wp && $past(q.phase) != 3'd0))
        else $error("sample stored during a partial read");
    a_wm_level: assert property (
        !wr ##1 !wr |-> watermark == (samples_of(q.fill, hi_res) >= 8'(q.th)))
        else $error("watermark disagrees with fill level");
    a_pre_limit: assert property (
        mode == ASB_TRIG && q.ts == TS_PRE && q.th != 7'h00 && !wr |=>
        q.fill <= thb || q.fill <= $past(q.fill))
        else $error("pre-trigger history exceeded threshold");
    a_trig_cause: assert property (
        $rose(trig_flag) |-> $past(engine_irq) && $past(mode) == ASB_TRIG)
        else $error("trigger flag set without engine interrupt");
    a_post_stops: assert property (
        q.ts == TS_DONE && mode == ASB_TRIG && !rd && !wr |=> $stable(q.wp))
        else $error("trigger buffer kept collecting after full");
    a_trig_event: assert property (
        mode == ASB_TRIG && engine_irq && q.ts == TS_PRE && !wr |=> q.ts == TS_POST)
        else $error("trigger event not taken");
endmodule
`default_nettype wire

/* File: rtl/asb_pkg.sv */
// Purpose : constants shared by the acceleration sample buffer
// Assumes : byte-wide register port, 100 MHz core clock
// Notes   : register offsets are word indices on the plain register port
package asb_pkg;
    // register map
    localparam logic [7:0] REG_CTRL   = 8'h00; // mode, resolution, output rate
    localparam logic [7:0] REG_THRESH = 8'h01; // sample threshold
    localparam logic [7:0] REG_STATUS = 8'h02; // watermark, trigger flag, phase
    localparam logic [7:0] REG_FILL   = 8'h03; // buffer fill level in bytes
    localparam logic [7:0] REG_ABOVE  = 8'h04; // samples above threshold
    localparam logic [7:0] REG_CLEAR  = 8'h05; // any write empties the buffer
    localparam logic [7:0] REG_DATA   = 8'h06; // buffer read port
    // control and status field positions
    localparam int CTRL_MODE_LSB = 0;          // two bits
    localparam int CTRL_RES_BIT  = 2;          // 1 = high resolution
    localparam int CTRL_RATE_LSB = 3;          // rate lsb, msb above it
    localparam int STAT_WM_BIT   = 0;
    localparam int STAT_TRIG_BIT = 1;
    // reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [6:0] THRESH_RST = 7'h00;
    // sample sizes in bytes
    localparam logic [7:0] BYTES_LO = 8'h03;
    localparam logic [7:0] BYTES_HI = 8'h06;
    // buffer depth in bytes, a multiple of six and below 256
    localparam int BUF_BYTES_DEF = 240;
    // output rate: slowest setting period; each step of the rate field halves it
    localparam int ODR_BASE_HZ  = 100;
    localparam int CLK_HZ       = 100_000_000;
    localparam int ODR_BASE_CYC = CLK_HZ / ODR_BASE_HZ;
    // buffer operating modes
    typedef enum logic [1:0] {
        ASB_FIFO   = 2'b00,
        ASB_STREAM = 2'b01,
        ASB_TRIG   = 2'b10,
        ASB_SPARE  = 2'b11
    } asb_mode_t;
    // trigger-mode progress, one-hot
    typedef enum logic [2:0] {
        TS_PRE  = 3'b001,
        TS_POST = 3'b010,
        TS_DONE = 3'b100
    } asb_tstate_t;
endpackage

/* File: verification/asb_link_src.sv */
// Purpose : sample front end model feeding the buffer on the link clock
// Assumes : a new sample every second link clock edge
// Notes   : axes are copied at each valid so they never move in mid-sample
`timescale 1ns/1ps
`default_nettype none
module asb_link_src (
    input  wire logic        link_clock, // link clock from the bench
    input  wire logic        rst,        // async reset, active high
    input  wire logic [35:0] smp,        // x, y, z wanted by the bench
    output logic             link_valid, // one link cycle per sample
    output logic      [11:0] link_x,     // x axis, two's complement
    output logic      [11:0] link_y,     // y axis
    output logic      [11:0] link_z      // z axis
);
    logic gap_q; // two link cycles apart keeps samples over eight core clocks
    //--------------------------------------------------------------------
    // sample emission
    //--------------------------------------------------------------------
    // axes change only beside valid and then hold until the next one
    always_ff @(posedge link_clock or posedge rst) begin
        if (rst) begin
            gap_q <= 1'b0;
            link_valid <= 1'b0;
            {link_x, link_y, link_z} <= 36'h0;
        end else begin
            gap_q <= ~gap_q;
            link_valid <= ~gap_q;
            if (!gap_q) begin
                {link_x, link_y, link_z} <= smp;
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_accel_sample_buffer.sv */
// Purpose : self-checking bench of the acceleration sample buffer
// Assumes : short output rate period and a six-sample buffer
// Notes   : trigger done state is used where counts must not move
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_accel_sample_buffer
    import asb_pkg::*;
;
    localparam int          ODR = 64;             // rate 0 period in clocks
    localparam logic [35:0] SA  = 36'h9A5123F0C; // first sample pattern
    localparam logic [35:0] SB  = 36'h3C78E1056; // second sample pattern
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        link_clock = 1'b0;
    logic        link_valid;
    logic [11:0] link_x, link_y, link_z;
    logic        engine_irq = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, d;
    logic        wr = 1'b0, rd = 1'b0, watermark, trig_flag;
    logic [35:0] smp = SA;
    int          miscompares = 0, n_checks = 0, t;
    //--------------------------------------------------------------------
    // clocks, design and sample source
    //--------------------------------------------------------------------
    always #5 clock = ~clock;
    // odd offset keeps the link edges unrelated to the core edges
    initial begin
        #3.3;
        forever #62.5 link_clock = ~link_clock;
    end
    asb_link_src src (.link_clock(link_clock), .rst(rst), .smp(smp),
        .link_valid(link_valid), .link_x(link_x), .link_y(link_y), .link_z(link_z));
    asb_buffer #(.BUF_BYTES(36), .ODR_CYC(ODR)) dut (.clock(clock), .rst(rst),
        .link_clock(link_clock), .link_valid(link_valid), .link_x(link_x),
        .link_y(link_y), .link_z(link_z), .engine_irq(engine_irq), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .watermark(watermark),
        .trig_flag(trig_flag));
    //--------------------------------------------------------------------
    // bus tasks and helpers
    //--------------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    function automatic logic [7:0] ebyte(logic [35:0] s, int i, logic hi);
        logic [11:0] ax;
        ax = hi ? s[35-12*(i/2) -: 12] : s[35-12*i -: 12];
        return (hi && i % 2 == 0) ? {ax[3:0], 4'h0} : ax[11:4];
    endfunction
    task automatic chk_smp(input logic [35:0] s, input logic hi, input bit en);
        logic [7:0] v;
        for (int i = 0; i < (hi ? 6 : 3); i++) begin
            rd_reg(REG_DATA, v);
            if (en) `CHK("sample byte", ebyte(s, i, hi), v);
        end
    endtask
    // polls the fill level; t returns clocks spent
    task automatic wait_fill(input logic [7:0] n, output int tc);
        logic [7:0] v;
        tc = 0;
        do begin
            rd_reg(REG_FILL, v);
            tc += 2;
        end while (v < n && tc < 4000);
        `CHK("fill wait", 1'b1, tc < 4000);
    endtask
    // the settle wait stops a stale latest sample landing after clear
    task automatic setup(input logic [1:0] m, input logic h, input logic [1:0] r,
                         input logic [6:0] th, input logic [35:0] s);
        smp <= s;
        wr_reg(REG_CTRL, {3'h0, r, h, m});
        wr_reg(REG_THRESH, {1'b0, th});
        repeat (60) @(posedge clock);
        wr_reg(REG_CLEAR, 8'h5A);
    endtask
    //--------------------------------------------------------------------
    // scenarios
    //--------------------------------------------------------------------
    task automatic t_reset();
        rd_reg(REG_CTRL, d);
        `CHK("ctrl reset", CTRL_RST, d);
        rd_reg(REG_THRESH, d);
        `CHK("thresh reset", {1'b0, THRESH_RST}, d);
        wr_reg(8'h7E, 8'hFF);
        rd_reg(8'h7E, d);
        `CHK("unmapped read", 8'h00, d);
        rd_reg(REG_DATA, d);
        `CHK("empty data read", 8'h00, d);
    endtask
    // each step of the rate field halves the capture period
    task automatic t_rate();
        for (int r = 0; r < 4; r++) begin
            setup(2'h0, 1'b1, r[1:0], 7'h00, SA);
            wait_fill(8'h06, t);
            wait_fill(8'h0C, t);
            `CHK("rate period", 1'b1, t >= (ODR >> r) - 3 && t <= (ODR >> r) + 3);
        end
    endtask
    task automatic t_order();
        setup(2'h0, 1'b1, 2'h0, 7'h00, SA);
        wait_fill(8'h06, t);
        smp <= SB;
        wait_fill(8'h0C, t);
        chk_smp(SA, 1'b1, 1'b1);
        chk_smp(SB, 1'b1, 1'b1);
        setup(2'h0, 1'b0, 2'h0, 7'h00, SA);
        wait_fill(8'h03, t);
        chk_smp(SA, 1'b0, 1'b1);
    endtask
    // fifo keeps the first samples when full, stream keeps the newest
    task automatic t_full(input logic [1:0] m, input int w, input logic [35:0] f);
        setup(m, 1'b1, 2'h0, 7'h00, SA);
        wait_fill(8'h24, t);
        smp <= SB;
        repeat (w) @(posedge clock);
        rd_reg(REG_FILL, d);
        `CHK("full fill", 8'h24, d);
        chk_smp(f, 1'b1, 1'b1);
    endtask
    task automatic t_trig();
        setup(2'h2, 1'b1, 2'h0, 7'h02, SA);
        wait_fill(8'h0C, t);
        smp <= SB;
        repeat (200) @(posedge clock);
        rd_reg(REG_FILL, d);
        `CHK("pre trigger fill", 8'h0C, d);
        `CHK("flag before event", 1'b0, trig_flag);
        `CHK("watermark at threshold", 1'b1, watermark);
        smp <= SA;
        @(posedge clock);
        engine_irq <= 1'b1;
        @(posedge clock);
        engine_irq <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK("trigger flag", 1'b1, trig_flag);
        wait_fill(8'h24, t);
        repeat (200) @(posedge clock);
        rd_reg(REG_FILL, d);
        `CHK("post trigger fill", 8'h24, d);
        rd_reg(REG_ABOVE, d);
        `CHK("samples above", 8'h04, d);
        chk_smp(SB, 1'b1, 1'b1);
        chk_smp(SB, 1'b1, 1'b1);
        rd_reg(REG_FILL, d);
        `CHK("fill after reads", 8'h18, d);
        chk_smp(SA, 1'b1, 1'b0);
        chk_smp(SA, 1'b1, 1'b1);
        `CHK("watermark two left", 1'b1, watermark);
        chk_smp(SA, 1'b1, 1'b1);
        `CHK("watermark one left", 1'b0, watermark);
        wr_reg(REG_CLEAR, 8'h00);
        rd_reg(REG_FILL, d);
        `CHK("clear fill", 8'h00, d);
        `CHK("clear flag", 1'b0, trig_flag);
    endtask
    //--------------------------------------------------------------------
    // sequence, verdict and watchdog
    //--------------------------------------------------------------------
    task automatic close_out();
        if (miscompares == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        @(negedge clock);
        `CHK("reset watermark", 1'b1, watermark);
        `CHK("reset flag", 1'b0, trig_flag);
        `CHK("reset rdata", 8'h00, rdata);
        @(posedge clock);
        @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_rate();
        t_order();
        t_full(2'h0, 200, SA);
        t_full(2'h1, 500, SB);
        t_trig();
        close_out();
    end
    // the whole run needs well under a quarter of this span
    initial begin
        #300000;
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire
